// ==== rtl/fwg_guard.sv ====
// Write guard, reset, power and secured region control for one flash die.
// Assumes a separate decoder turns bus words into command kinds and that
// the array engine reports completion of program or erase.
`timescale 1ns/1ns
`default_nettype none
module fwg_guard #(
  parameter int NUM_SECT = 16,
  parameter int SECT_W = 4,
  parameter logic [NUM_SECT-1:0] BOOT_MASK = 16'hC003,
  parameter logic [SECT_W-1:0] FIRST_SECTOR = 4'h0,
  parameter int GLITCH_CYCLES = fwg_pkg::GLITCH_CYC,
  parameter int SLEEP_CYCLES = fwg_pkg::SLEEP_CYC,
  parameter int RP_CYCLES = fwg_pkg::RESET_PULSE_CYC,
  parameter int RH_CYCLES = fwg_pkg::RESET_RELEASE_CYC,
  parameter int POLL_CYCLES = fwg_pkg::POLL_CYC
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic chip_enable_n,
  input wire logic write_enable_n,
  input wire logic output_enable_n,
  input wire logic hw_reset_n,
  input wire logic write_protect_n,
  input wire logic supply_low,
  input wire logic [23:0] bus_addr,
  input wire fwg_pkg::fwg_cmd_t cmd_kind,
  input wire logic [SECT_W-1:0] cmd_sector,
  input wire logic [7:0] cmd_word,
  input wire logic cmd_accel,
  input wire logic [15:0] cmd_cfg_data,
  input wire logic [NUM_SECT-1:0] sector_protect,
  input wire logic cust_lock_init,
  input wire logic [2:0] lock_mode_bits,
  input wire logic array_op_done,
  output logic write_accept,
  output logic op_start,
  output logic op_to_region,
  output logic op_abort,
  output logic busy,
  output logic status_poll,
  output logic dq_oe,
  output logic data_latch,
  output logic auto_sleep,
  output logic region_mapped,
  output logic region_read,
  output logic read_invalid,
  output logic read_ready,
  output logic [15:0] region_indicators,
  output logic [15:0] lock_word,
  output logic [15:0] config_word
);
  import fwg_pkg::*;

  localparam int SLW = $clog2(SLEEP_CYCLES + 2);
  localparam int RPW = $clog2(RP_CYCLES + 2);
  localparam int RHW = $clog2(RH_CYCLES + 2);
  localparam int PW = $clog2(POLL_CYCLES + 2);

  fwg_state_t state_r;
  fwg_state_t state_nxt;
  logic [2:0] ctl_n;
  logic ce_n;
  logic we_n;
  logic oe_n;
  logic wr_active;
  logic wr_active_r;
  logic wr_end;
  logic armed_r;
  logic lock_loaded_r;
  logic cust_lock_r;
  logic mapped_r;
  logic aborted_r;
  logic in_reset;
  logic [RPW-1:0] rp_cnt_r;
  logic [RHW-1:0] rh_cnt_r;
  logic [PW-1:0] poll_cnt_r;
  logic [SLW-1:0] sleep_cnt_r;
  logic [23:0] addr_last_r;
  logic take_cmd;
  logic is_pe;
  logic hits_region;
  logic boot_hit;
  logic blocked;
  logic sync_mode;

  // Glitch filter on the three strobes; the filtered copies drive all decisions except arming, which also checks the raw pins.
  fwg_glitch_filter #(
    .WIDTH(3),
    .STABLE_CYC(GLITCH_CYCLES)
  ) u_filter (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .raw_n({output_enable_n, write_enable_n, chip_enable_n}),
    .clean_n(ctl_n)
  );

  assign ce_n = ctl_n[0];
  assign we_n = ctl_n[1];
  assign oe_n = ctl_n[2];

  // A write cycle is open only with both enables low and output enable high.
  assign wr_active = !ce_n && !we_n && oe_n;
  assign wr_end = wr_active_r && !wr_active;
  assign in_reset = !hw_reset_n;
  assign sync_mode = config_word[CFG_SYNC_BIT];

  // Commands count only at a clean write end, outside lockout and reset.
  assign take_cmd = wr_end && armed_r && !supply_low && !in_reset;

  assign is_pe = (cmd_kind == FWG_CMD_PROGRAM) || (cmd_kind == FWG_CMD_ERASE);
  // The first sector's addresses are overlaid only while mapped.
  assign hits_region = mapped_r && (cmd_sector == FIRST_SECTOR);
  assign boot_hit = BOOT_MASK[cmd_sector] && !write_protect_n;

  // Protection check for a program or erase that has been taken.
  always_comb begin
    blocked = 1'b0;
    if (hits_region) begin
      if (cmd_kind == FWG_CMD_ERASE) begin
        blocked = 1'b1;
      end else if (cmd_word < CUST_BASE) begin
        blocked = 1'b1;
      end else begin
        blocked = cust_lock_r || cmd_accel;
      end
    end else begin
      // Write protect high defers to the sector's own protection state.
      blocked = boot_hit || sector_protect[cmd_sector];
    end
  end

  // Write-cycle edge tracker.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_active_r <= 1'b0;
    end else begin
      wr_active_r <= wr_active;
    end
  end

  // After power-up the raw and filtered strobes must both be seen idle, since
  // the filter resets to idle, so a write enable held low cannot land a command.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      armed_r <= 1'b0;
    end else if (!wr_active && !(!chip_enable_n && !write_enable_n && output_enable_n)
        && hw_reset_n) begin
      armed_r <= 1'b1;
    end
  end

  // Reset pulse width counter; short dips on the reset pin never reach the reset state.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rp_cnt_r <= '0;
    end else if (!in_reset) begin
      rp_cnt_r <= '0;
    end else if (rp_cnt_r < RPW'(RP_CYCLES)) begin
      rp_cnt_r <= rp_cnt_r + 1'b1;
    end
  end

  // Next-state logic for the embedded operation sequencer.
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      FWG_ST_READ: begin
        if (take_cmd && is_pe) begin
          state_nxt = blocked ? FWG_ST_POLL : FWG_ST_BUSY;
        end
      end
      FWG_ST_BUSY: begin
        // Chip enable is not looked at here: deselect never ends the job.
        if (array_op_done) begin
          state_nxt = FWG_ST_READ;
        end
      end
      FWG_ST_POLL: begin
        if (poll_cnt_r == '0) begin
          state_nxt = FWG_ST_READ;
        end
      end
      FWG_ST_RESET: begin
        if (!in_reset) begin
          state_nxt = aborted_r ? FWG_ST_RECOVER : FWG_ST_READ;
        end
      end
      FWG_ST_RECOVER: begin
        if (rh_cnt_r == '0) begin
          state_nxt = FWG_ST_READ;
        end
      end
    endcase
    // A full reset pulse overrides everything else; lockout overrides all but the reset state.
    if (in_reset && rp_cnt_r >= RPW'(RP_CYCLES)) begin
      state_nxt = FWG_ST_RESET;
    end else if (supply_low && state_r != FWG_ST_RESET) begin
      state_nxt = FWG_ST_READ;
    end
  end

  // State register; power-up lands in array read.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= FWG_ST_READ;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Remember whether the reset pulse cut into a running operation.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      aborted_r <= 1'b0;
    end else if (state_nxt == FWG_ST_RESET && state_r == FWG_ST_BUSY) begin
      aborted_r <= 1'b1;
    end else if (state_r == FWG_ST_READ) begin
      aborted_r <= 1'b0;
    end
  end

  // Recovery timer after a reset that aborted an operation.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rh_cnt_r <= '0;
    end else if (state_r == FWG_ST_RESET) begin
      rh_cnt_r <= RHW'(RH_CYCLES - 1);
    end else if (rh_cnt_r != '0) begin
      rh_cnt_r <= rh_cnt_r - 1'b1;
    end
  end

  // Status polling window shown for a rejected program or erase.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      poll_cnt_r <= '0;
    end else if (state_nxt == FWG_ST_POLL && state_r != FWG_ST_POLL) begin
      poll_cnt_r <= PW'(POLL_CYCLES - 1);
    end else if (poll_cnt_r != '0) begin
      poll_cnt_r <= poll_cnt_r - 1'b1;
    end
  end

  // Operation handshake outputs toward the array engine.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      write_accept <= 1'b0;
      op_start <= 1'b0;
      op_to_region <= 1'b0;
      op_abort <= 1'b0;
      busy <= 1'b0;
      status_poll <= 1'b0;
    end else begin
      write_accept <= take_cmd && state_r == FWG_ST_READ;
      op_start <= state_r == FWG_ST_READ && state_nxt == FWG_ST_BUSY;
      if (state_r == FWG_ST_READ && state_nxt == FWG_ST_BUSY) begin
        op_to_region <= hits_region;
      end
      // Abort for either a reset pulse or a supply lockout mid-operation.
      op_abort <= state_r == FWG_ST_BUSY && state_nxt != FWG_ST_BUSY
        && !array_op_done;
      busy <= state_nxt == FWG_ST_BUSY;
      status_poll <= state_nxt == FWG_ST_POLL;
    end
  end

  // Region mapping: enter and exit commands, cleared by a full reset pulse.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      mapped_r <= 1'b0;
    end else if (state_nxt == FWG_ST_RESET) begin
      mapped_r <= 1'b0;
    end else if (take_cmd && state_r == FWG_ST_READ) begin
      if (cmd_kind == FWG_CMD_ENTER) begin
        mapped_r <= 1'b1;
      end else if (cmd_kind == FWG_CMD_EXIT) begin
        mapped_r <= 1'b0;
      end
    end
  end

  // The customer lock bit is non-volatile: loaded once from the strap after
  // power-up, then it can only be set. No path ever clears it.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      lock_loaded_r <= 1'b0;
      cust_lock_r <= 1'b0;
    end else if (!lock_loaded_r) begin
      lock_loaded_r <= 1'b1;
      cust_lock_r <= cust_lock_init;
    end else if (take_cmd && state_r == FWG_ST_READ && mapped_r
        && cmd_kind == FWG_CMD_LOCK) begin
      cust_lock_r <= 1'b1;
    end
  end

  // Configuration register; cleared by a reset pulse.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      config_word <= CFG_RESET;
    end else if (state_nxt == FWG_ST_RESET) begin
      config_word <= CFG_RESET;
    end else if (take_cmd && state_r == FWG_ST_READ && cmd_kind == FWG_CMD_CONFIG) begin
      config_word <= cmd_cfg_data;
    end
  end

  // Address stability timer for automatic sleep in asynchronous mode only.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      addr_last_r <= '0;
      sleep_cnt_r <= '0;
      auto_sleep <= 1'b0;
    end else begin
      addr_last_r <= bus_addr;
      if (bus_addr != addr_last_r || sync_mode) begin
        sleep_cnt_r <= '0;
        auto_sleep <= 1'b0;
      end else if (sleep_cnt_r < SLW'(SLEEP_CYCLES)) begin
        sleep_cnt_r <= sleep_cnt_r + 1'b1;
      end else begin
        auto_sleep <= 1'b1;
      end
    end
  end

  // Output drive: off in standby, with output enable high, or in reset.
  // Data stays latched while asleep so a held address keeps its word.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      dq_oe <= 1'b0;
      data_latch <= 1'b0;
    end else begin
      dq_oe <= !ce_n && !oe_n && hw_reset_n;
      data_latch <= auto_sleep && !sync_mode;
    end
  end

  // Read routing while the region is mapped over the first sector.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      region_read <= 1'b0;
      read_invalid <= 1'b0;
      region_mapped <= 1'b0;
    end else begin
      region_mapped <= mapped_r;
      region_read <= hits_region && !ce_n && !oe_n;
      read_invalid <= hits_region
        && bus_addr[23:8] != 16'h0000;
    end
  end

  // Readiness for array reads and the indicator and lock words.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      read_ready <= 1'b0;
      region_indicators <= 16'h0000;
      lock_word <= 16'hFFFF;
    end else begin
      read_ready <= state_nxt == FWG_ST_READ || state_nxt == FWG_ST_POLL;
      region_indicators <= {8'h00, 1'b1, cust_lock_r, 6'h00};
      lock_word <= {LOCK_UPPER_ONES, 1'b1, lock_mode_bits[1:0],
        !cust_lock_r};
    end
  end

endmodule : fwg_guard
`default_nettype wire

// ==== rtl/fwg_pkg.sv ====
// Constants, states and command codes of the flash write guard.
// Assumes one 10 MHz system clock; the caller decodes bus command words.
package fwg_pkg;

  // Clock and timing figures.
  localparam int CLK_NS = 100;
  localparam int GLITCH_NS = 3;
  localparam int SLEEP_EXTRA_NS = 20;
  localparam int ACCESS_NS = 70;
  localparam int RESET_PULSE_NS = 200;
  localparam int RESET_RELEASE_NS = 200;
  localparam int POLL_NS = 400;

  // Least times round up to whole cycles, never below one.
  localparam int GLITCH_CYC = (GLITCH_NS + CLK_NS - 1) / CLK_NS;
  localparam int SLEEP_CYC = (ACCESS_NS + SLEEP_EXTRA_NS + CLK_NS - 1) / CLK_NS;
  localparam int RESET_PULSE_CYC = (RESET_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int RESET_RELEASE_CYC = (RESET_RELEASE_NS + CLK_NS - 1) / CLK_NS;
  localparam int POLL_CYC = (POLL_NS + CLK_NS - 1) / CLK_NS;

  // Secured region layout in words.
  localparam int REGION_WORDS = 256;
  localparam logic [7:0] CUST_BASE = 8'h80;
  localparam logic [15:0] CFG_RESET = 16'h0000;
  localparam int CFG_SYNC_BIT = 15;
  localparam logic [11:0] LOCK_UPPER_ONES = 12'hFFF;

  // Decoded command kinds handed in at the end of a write cycle.
  typedef enum logic [2:0] {
    FWG_CMD_NONE = 3'h0,
    FWG_CMD_PROGRAM = 3'h1,
    FWG_CMD_ERASE = 3'h2,
    FWG_CMD_ENTER = 3'h3,
    FWG_CMD_EXIT = 3'h4,
    FWG_CMD_LOCK = 3'h5,
    FWG_CMD_CONFIG = 3'h6
  } fwg_cmd_t;

  // Internal state machine states.
  typedef enum logic [4:0] {
    FWG_ST_READ = 5'h01,
    FWG_ST_BUSY = 5'h02,
    FWG_ST_POLL = 5'h04,
    FWG_ST_RESET = 5'h08,
    FWG_ST_RECOVER = 5'h10
  } fwg_state_t;

endpackage : fwg_pkg

// ==== rtl/fwg_glitch_filter.sv ====
// Deglitcher for the active-low bus control pins.
// Assumes inputs already synchronous to sys_clk.
`timescale 1ns/1ns
`default_nettype none
module fwg_glitch_filter #(
  parameter int WIDTH = 3,
  parameter int STABLE_CYC = 1
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] raw_n,
  output logic [WIDTH-1:0] clean_n
);
  import fwg_pkg::*;

  localparam int CW = $clog2(STABLE_CYC + 1);

  // Each pin must hold a new level for STABLE_CYC samples before it counts.
  // At 10 MHz a one-cycle hold already swallows any few-ns spike.
  for (genvar i = 0; i < WIDTH; i++) begin : g_pin
    logic [CW-1:0] cnt_r;
    always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
        cnt_r <= '0;
        clean_n[i] <= 1'b1;
      end else if (raw_n[i] == clean_n[i]) begin
        cnt_r <= '0;
      end else if (cnt_r >= CW'(STABLE_CYC - 1)) begin
        cnt_r <= '0;
        clean_n[i] <= raw_n[i];
      end else begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end

endmodule : fwg_glitch_filter
`default_nettype wire

// ==== bench/fwg_guard_props.sv ====
// Checker: port-level properties of the flash write guard.
// Assumes the host holds command fields until the accept pulse has passed.
`timescale 1ns/1ns
`default_nettype none
module fwg_guard_props #(
  parameter int NUM_SECT = 16,
  parameter int SECT_W = 4,
  parameter logic [NUM_SECT-1:0] BOOT_MASK = 16'hC003,
  parameter logic [SECT_W-1:0] FIRST_SECTOR = 4'h0
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic chip_enable_n,
  input wire logic output_enable_n,
  input wire logic hw_reset_n,
  input wire logic write_protect_n,
  input wire logic supply_low,
  input wire fwg_pkg::fwg_cmd_t cmd_kind,
  input wire logic [SECT_W-1:0] cmd_sector,
  input wire logic [7:0] cmd_word,
  input wire logic [NUM_SECT-1:0] sector_protect,
  input wire logic array_op_done,
  input wire logic write_accept,
  input wire logic op_start,
  input wire logic busy,
  input wire logic dq_oe,
  input wire logic region_mapped,
  input wire logic [15:0] region_indicators,
  input wire logic [15:0] lock_word,
  input wire logic [15:0] config_word
);
  import fwg_pkg::*;
  logic region_hit;

  // Every property runs on the system clock and sleeps through power-up reset.
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  // A launch into the overlaid first sector must meet the region limits.
  assign region_hit = op_start && region_mapped && (cmd_sector == FIRST_SECTOR);

  property p_boot;
    op_start |-> !(BOOT_MASK[cmd_sector] && !write_protect_n);
  endproperty
  a_boot: assert property (p_boot)
    else $error("boot sector launched under write protect");
  property p_protect;
    op_start |-> !sector_protect[cmd_sector];
  endproperty
  a_protect: assert property (p_protect)
    else $error("protected sector launched");
  property p_hw_ignore;
    !hw_reset_n && !$past(hw_reset_n) |-> !write_accept;
  endproperty
  a_hw_ignore: assert property (p_hw_ignore)
    else $error("command taken during hardware reset");
  // Output enable must settle through the filter and the register first.
  property p_out_off;
    (output_enable_n || chip_enable_n) [*4] |=> !dq_oe;
  endproperty
  a_out_off: assert property (p_out_off)
    else $error("data outputs driven while disabled");
  property p_busy_hold;
    busy && hw_reset_n && !supply_low && !array_op_done && !$past(array_op_done) |=> busy;
  endproperty
  a_busy_hold: assert property (p_busy_hold)
    else $error("running operation ended early");
  property p_factory;
    region_hit |-> (cmd_kind == FWG_CMD_PROGRAM) && (cmd_word >= CUST_BASE);
  endproperty
  a_factory: assert property (p_factory)
    else $error("factory part or region erase launched");
  property p_cust_lock;
    region_hit |-> !region_indicators[6];
  endproperty
  a_cust_lock: assert property (p_cust_lock)
    else $error("locked customer part launched");
  property p_indic;
    $past(rst_b) |-> region_indicators[7] && (&lock_word[15:3])
      && (lock_word[0] == !region_indicators[6]);
  endproperty
  a_indic: assert property (p_indic)
    else $error("lock indicators inconsistent");
  property p_reset_map;
    !hw_reset_n [*4] |=> !region_mapped && !dq_oe && (config_word == CFG_RESET);
  endproperty
  a_reset_map: assert property (p_reset_map)
    else $error("hardware reset left mapping or configuration");
endmodule : fwg_guard_props

bind fwg_guard fwg_guard_props #(.NUM_SECT(NUM_SECT), .SECT_W(SECT_W), .BOOT_MASK(BOOT_MASK),
  .FIRST_SECTOR(FIRST_SECTOR)) u_fwg_guard_props (.sys_clk(sys_clk), .rst_b(rst_b),
  .chip_enable_n(chip_enable_n), .output_enable_n(output_enable_n), .hw_reset_n(hw_reset_n),
  .write_protect_n(write_protect_n), .supply_low(supply_low), .cmd_kind(cmd_kind),
  .cmd_sector(cmd_sector), .cmd_word(cmd_word), .sector_protect(sector_protect),
  .array_op_done(array_op_done), .write_accept(write_accept), .op_start(op_start),
  .busy(busy), .dq_oe(dq_oe), .region_mapped(region_mapped),
  .region_indicators(region_indicators), .lock_word(lock_word), .config_word(config_word));
`default_nettype wire

// ==== bench/fwg_host_model.sv ====
// Host model: a memory controller issuing single write cycles.
// Assumes callers enter its tasks just after a falling clock edge.
`timescale 1ns/1ns
`default_nettype none
module fwg_host_model (
  input wire logic sys_clk,
  output logic chip_enable_n,
  output logic write_enable_n,
  output logic output_enable_n,
  output logic write_protect_n,
  output var fwg_pkg::fwg_cmd_t cmd_kind,
  output logic [3:0] cmd_sector,
  output logic [7:0] cmd_word,
  output logic cmd_accel
);
  import fwg_pkg::*;

  // Power-up pin state: selected, write low, outputs off.
  initial begin
    chip_enable_n = 1'b0;
    write_enable_n = 1'b0;
    output_enable_n = 1'b1;
    write_protect_n = 1'b1;
    cmd_kind = FWG_CMD_NONE;
    cmd_sector = 4'h0;
    cmd_word = 8'h00;
    cmd_accel = 1'b0;
  end

  // Deselects after power-up; the write rise here must not count.
  task automatic release_bus;
    @(negedge sys_clk);
    write_enable_n = 1'b1;
    chip_enable_n = 1'b1;
  endtask : release_bus

  // Write protect settles a cycle early and stays put for the cycle.
  task automatic write_cycle(input fwg_cmd_t k, input logic [3:0] s, input logic [7:0] w,
                             input logic a, input logic wp, input logic oe);
    @(negedge sys_clk);
    write_protect_n = wp;
    @(negedge sys_clk);
    cmd_kind = k;
    cmd_sector = s;
    cmd_word = w;
    cmd_accel = a;
    output_enable_n = oe;
    chip_enable_n = 1'b0;
    write_enable_n = 1'b0;
    repeat (2) @(negedge sys_clk);
    write_enable_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    // Released sector, word and accel show inverted values and the kind shows none, so stale data cannot pass.
    chip_enable_n = 1'b1;
    output_enable_n = 1'b1;
    cmd_kind = FWG_CMD_NONE;
    cmd_sector = ~s;
    cmd_word = ~w;
    cmd_accel = ~a;
  endtask : write_cycle

  // Opens a read aimed at sector s when on is high, closes it otherwise.
  task automatic read_bus(input logic [3:0] s, input logic on);
    @(negedge sys_clk);
    cmd_sector = s;
    chip_enable_n = !on;
    output_enable_n = !on;
  endtask : read_bus
endmodule : fwg_host_model
`default_nettype wire

// ==== bench/testbench.sv ====
// Testbench for the flash write guard with a host model on the bus side.
// Assumes default timing parameters; expectations come from bench functions.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import fwg_pkg::*;
  logic sys_clk, rst_b, hw_reset_n, supply_low, cust_lock_init, array_op_done;
  logic [23:0] bus_addr;
  logic [15:0] cmd_cfg_data, sector_protect;
  logic [2:0] lock_mode_bits;
  logic ce_n, we_n, oe_n, wp_n, accel;
  fwg_cmd_t kind;
  logic [3:0] sect;
  logic [7:0] word;
  logic write_accept, op_start, op_to_region, op_abort, busy, status_poll, dq_oe;
  logic data_latch, auto_sleep, region_mapped, region_read, read_invalid, read_ready;
  logic [15:0] region_indicators, lock_word, config_word;
  int n_fail, check_count, n_acc, n_start, n_poll, n_abort;
  integer seed;
  logic [31:0] r;
  logic mapped, locked;

  fwg_host_model u_fwg_host_model (.sys_clk(sys_clk), .chip_enable_n(ce_n),
    .write_enable_n(we_n), .output_enable_n(oe_n), .write_protect_n(wp_n), .cmd_kind(kind),
    .cmd_sector(sect), .cmd_word(word), .cmd_accel(accel));

  fwg_guard u_fwg_guard (.sys_clk(sys_clk), .rst_b(rst_b), .chip_enable_n(ce_n),
    .write_enable_n(we_n), .output_enable_n(oe_n), .hw_reset_n(hw_reset_n),
    .write_protect_n(wp_n), .supply_low(supply_low), .bus_addr(bus_addr), .cmd_kind(kind),
    .cmd_sector(sect), .cmd_word(word), .cmd_accel(accel), .cmd_cfg_data(cmd_cfg_data),
    .sector_protect(sector_protect), .cust_lock_init(cust_lock_init),
    .lock_mode_bits(lock_mode_bits), .array_op_done(array_op_done),
    .write_accept(write_accept), .op_start(op_start), .op_to_region(op_to_region),
    .op_abort(op_abort), .busy(busy), .status_poll(status_poll), .dq_oe(dq_oe),
    .data_latch(data_latch), .auto_sleep(auto_sleep), .region_mapped(region_mapped),
    .region_read(region_read), .read_invalid(read_invalid), .read_ready(read_ready),
    .region_indicators(region_indicators), .lock_word(lock_word), .config_word(config_word));

  // Free-running 10 MHz clock.
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // Pulses are counted on the sampling edge so none can slip by.
  always @(posedge sys_clk) begin
    if (write_accept === 1'b1) n_acc++;
    if (op_start === 1'b1) n_start++;
    if (status_poll === 1'b1) n_poll++;
    if (op_abort === 1'b1) n_abort++;
  end

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // Launch expected for a command, from the protection and region limits.
  function automatic logic exp_start(fwg_cmd_t k, logic [3:0] s, logic [7:0] w, logic a,
                                     logic wp);
    if (k != FWG_CMD_PROGRAM && k != FWG_CMD_ERASE) return 1'b0;
    if ((16'hC003 >> s) & 16'h1 & {15'h0, !wp}) return 1'b0;
    if (sector_protect[s]) return 1'b0;
    if (mapped && s == 4'h0 && (k == FWG_CMD_ERASE || w < CUST_BASE || locked || a))
      return 1'b0;
    return 1'b1;
  endfunction : exp_start

  // One command from the host, then the engine completion and a quiet gap.
  task automatic do_cmd(input fwg_cmd_t k, input logic [3:0] s, input logic [7:0] w,
                        input logic a, input logic wp, input logic oe);
    logic acc_e;
    logic start_e;
    acc_e = oe && !supply_low;
    start_e = acc_e && exp_start(k, s, w, a, wp);
    n_acc = 0;
    n_start = 0;
    n_poll = 0;
    u_fwg_host_model.write_cycle(k, s, w, a, wp, oe);
    repeat (3) @(negedge sys_clk);
    check("accept", {15'h0, acc_e}, 16'(n_acc));
    check("start", {15'h0, start_e}, 16'(n_start));
    if (k == FWG_CMD_PROGRAM || k == FWG_CMD_ERASE)
      check("poll", {15'h0, acc_e && !start_e}, {15'h0, n_poll != 0});
    array_op_done = 1'b1;
    @(negedge sys_clk);
    array_op_done = 1'b0;
    repeat (8) @(negedge sys_clk);
  endtask : do_cmd

  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : final_report

  // A hang is cut short well past the expected run of about 1,340 cycles.
  initial begin
    #2000000;
    n_fail++;
    final_report();
  end

  // Main sequence: corner cases first, then random commands.
  initial begin
    seed = 32'h4809;
    {rst_b, hw_reset_n, supply_low, cust_lock_init, array_op_done} = 5'h0;
    bus_addr = 24'h0;
    cmd_cfg_data = 16'h8000;
    sector_protect = 16'h0;
    lock_mode_bits = 3'h5;
    {mapped, locked, n_fail, check_count, n_acc, n_start, n_poll, n_abort} = '0;
    repeat (16) @(posedge sys_clk);
    @(negedge sys_clk);
    rst_b = 1'b1;
    hw_reset_n = 1'b1;
    repeat (3) @(negedge sys_clk);
    u_fwg_host_model.release_bus();
    repeat (6) @(negedge sys_clk);
    check("powerup", 16'h0, 16'(n_acc));
    check("lock_word", 16'hFFFB, lock_word);
    check("indic", 16'h2, {14'h0, region_indicators[7:6]});
    do_cmd(FWG_CMD_CONFIG, 4'h3, 8'h00, 1'b0, 1'b1, 1'b1);
    check("sleep_sync", 16'h8000, {config_word[15], 14'h0, auto_sleep});
    cmd_cfg_data = 16'h0000;
    do_cmd(FWG_CMD_CONFIG, 4'h3, 8'h00, 1'b0, 1'b1, 1'b1);
    bus_addr = 24'h012345;
    repeat (5) @(negedge sys_clk);
    check("sleep_async", 16'h3, {14'h0, auto_sleep, data_latch});
    do_cmd(FWG_CMD_PROGRAM, 4'h5, 8'h00, 1'b0, 1'b1, 1'b0);
    supply_low = 1'b1;
    do_cmd(FWG_CMD_PROGRAM, 4'h5, 8'h00, 1'b0, 1'b1, 1'b1);
    supply_low = 1'b0;
    do_cmd(FWG_CMD_ERASE, 4'hF, 8'h00, 1'b0, 1'b0, 1'b1);
    do_cmd(FWG_CMD_ERASE, 4'hF, 8'h00, 1'b0, 1'b1, 1'b1);
    do_cmd(FWG_CMD_ENTER, 4'h0, 8'h00, 1'b0, 1'b1, 1'b1);
    mapped = 1'b1;
    do_cmd(FWG_CMD_PROGRAM, 4'h0, 8'h7F, 1'b0, 1'b1, 1'b1);
    do_cmd(FWG_CMD_PROGRAM, 4'h0, 8'h80, 1'b1, 1'b1, 1'b1);
    do_cmd(FWG_CMD_PROGRAM, 4'h0, 8'h80, 1'b0, 1'b1, 1'b1);
    check("to_region", 16'h1, {15'h0, op_to_region});
    do_cmd(FWG_CMD_ERASE, 4'h5, 8'h00, 1'b0, 1'b1, 1'b1);
    u_fwg_host_model.read_bus(4'h0, 1'b1);
    bus_addr = 24'h000100;
    repeat (3) @(negedge sys_clk);
    check("invalid", 16'h1, {15'h0, read_invalid});
    bus_addr = 24'h0000FF;
    repeat (3) @(negedge sys_clk);
    check("region_read", 16'h2, {14'h0, region_read, read_invalid});
    u_fwg_host_model.read_bus(4'hA, 1'b0);
    do_cmd(FWG_CMD_LOCK, 4'h0, 8'h00, 1'b0, 1'b1, 1'b1);
    locked = 1'b1;
    check("locked", 16'hFFFA, {region_indicators[7:6], lock_word[13:0]});
    do_cmd(FWG_CMD_PROGRAM, 4'h0, 8'hC0, 1'b0, 1'b1, 1'b1);
    do_cmd(FWG_CMD_EXIT, 4'h0, 8'h00, 1'b0, 1'b1, 1'b1);
    do_cmd(FWG_CMD_ENTER, 4'h0, 8'h00, 1'b0, 1'b1, 1'b1);
    cmd_cfg_data = 16'h8000;
    do_cmd(FWG_CMD_CONFIG, 4'h3, 8'h00, 1'b0, 1'b1, 1'b1);
    // Hardware reset lands while a program is running.
    n_abort = 0;
    u_fwg_host_model.write_cycle(FWG_CMD_PROGRAM, 4'h6, 8'h00, 1'b0, 1'b1, 1'b1);
    hw_reset_n = 1'b0;
    repeat (5) @(negedge sys_clk);
    check("abort", 16'h1, 16'(n_abort));
    check("reset_clear", 16'h0, {config_word[15:1], region_mapped});
    hw_reset_n = 1'b1;
    @(negedge sys_clk);
    check("recover", 16'h0, {15'h0, read_ready});
    repeat (5) @(negedge sys_clk);
    check("ready", 16'h1, {15'h0, read_ready});
    mapped = 1'b0;
    for (int i = 0; i < 48; i++) begin
      r = $random(seed);
      sector_protect = r[15:0] & 16'h1111;
      lock_mode_bits = r[18:16];
      bus_addr = {8'h00, r[31:16]};
      if (r[20] && r[21]) begin
        do_cmd(mapped ? FWG_CMD_EXIT : FWG_CMD_ENTER, 4'h0, 8'h00, 1'b0, 1'b1, 1'b1);
        mapped = !mapped;
      end else begin
        do_cmd(r[22] ? FWG_CMD_ERASE : FWG_CMD_PROGRAM, r[27:24], r[15:8], r[23] & r[19],
               r[28] | r[29], 1'b1);
      end
    end
    final_report();
  end
endmodule : testbench
`default_nettype wire
